// ===== hw/sfc_params.svh
// Constants of the serial flash command port.
// Assumes inclusion by bare name from hw/ sources.
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

// =====================================
// Opcodes
`define SFC_OP_READ 8'h03
`define SFC_OP_FAST 8'h0B
`define SFC_OP_DUAL 8'h3B
`define SFC_OP_DIO 8'hBB
`define SFC_OP_ERS_S1 8'h20
`define SFC_OP_ERS_S2 8'hD7
`define SFC_OP_ERS_SEC 8'hD8
`define SFC_OP_ERS_C1 8'h60
`define SFC_OP_ERS_C2 8'hC7
`define SFC_OP_PROG 8'h02
`define SFC_OP_WEN 8'h06
`define SFC_OP_WDIS 8'h04
`define SFC_OP_PDOWN 8'hB9
`define SFC_OP_RDST 8'h05
`define SFC_OP_WRST 8'h01
`define SFC_OP_ID 8'h9F
`define SFC_OP_LEGACY 8'hAB

// =====================================
// Phase lengths in serial clocks
`define SFC_CLK_BYTE 5'h08
`define SFC_CLK_ADDR_X1 5'h18
`define SFC_CLK_ADDR_X2 5'h0C
`define SFC_CLK_DUMMY_FAST 5'h08
`define SFC_CLK_DUMMY_DIO 5'h04
`define SFC_CLK_DUMMY_LEGACY 5'h18

// =====================================
// Identities (values arbitrary) and reset values
`define SFC_ID_STD 24'h5A3C11
`define SFC_ID_LEGACY 8'h4E
`define SFC_ADDR_MAX 19'h7FFFF
`define SFC_RST_WEL 1'h0
`define SFC_RST_PDOWN 1'h0

`endif

// ===== hw/sfc_pkg.sv
// Types shared by the serial flash command port.
// Assumes nothing beyond a SystemVerilog compiler.
package sfc_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_DUMMY = 7'h08,
    ST_OUT = 7'h10,
    ST_IN = 7'h20,
    ST_SKIP = 7'h40
  } sfc_state_e;
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_ERASE_SMALL = 3'h1,
    K_ERASE_SECTOR = 3'h2,
    K_ERASE_CHIP = 3'h3,
    K_PROGRAM = 3'h4,
    K_STATUS_WR = 3'h5
  } sfc_kind_e;
  typedef enum logic [1:0] {
    SRC_ARRAY = 2'h0,
    SRC_STATUS = 2'h1,
    SRC_ID = 2'h2,
    SRC_LEGACY = 2'h3
  } sfc_src_e;
endpackage

// ===== hw/sfc_sync.sv
// Two-flop synchroniser for pin inputs.
// Assumes asynchronous levels; first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module sfc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // RST_VAL must match each pin's idle level, or a false edge follows reset
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // sfc_sync
`default_nettype wire

// ===== hw/sfc_buf.sv
// Shift buffer with valid/ready on both sides; head is slot 0.
// Assumes one clock; in_ready low only when every slot is full.
`timescale 1ns/100ps
`default_nettype none
module sfc_buf #(
  parameter int W = 8,
  parameter int D = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_reg [D];
  logic [D-1:0] occ_reg;
  logic [D-1:0] occ_sh;
  logic [D:0] occ_lo;
  logic pop;
  logic push;

  assign pop = occ_reg[0] & out_ready;
  assign in_ready = ~occ_reg[D-1];
  assign push = in_valid & in_ready;
  assign occ_sh = pop ? (occ_reg >> 1) : occ_reg;
  // Slot below each slot is filled; slot 0 always has room below
  assign occ_lo = {occ_sh, 1'b1};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      occ_reg <= '0;
    else
      for (int i = 0; i < D; i++)
        occ_reg[i] <= occ_sh[i] | (push & occ_lo[i]);
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < D; i++)
    begin
      if (push && !occ_sh[i] && occ_lo[i])
        mem_reg[i] <= in_data;
      else if (pop && i < D - 1)
        mem_reg[i] <= mem_reg[(i < D - 1) ? i + 1 : i];
    end
  end

  assign out_valid = occ_reg[0];
  assign out_data = mem_reg[0];
endmodule // sfc_buf
`default_nettype wire

// ===== hw/sfc_port.sv
// Serial command front end of a serial flash, oversampling the link.
// Assumes CLOCK at least 8x the serial clock; RD_DATA follows RD_ADDR
// within two CLOCK cycles; erase/program engines sit behind CMD_STB.
// Notes on behaviour
// - Bits are taken on serial clock rise
// - Output bits change on serial clock fall
// - Dual modes turn both lines around
// - Active only while select low, else standby
// - Write-protect low enforces status write lock
// - Hold low suspends the serial link
// - Select fall starts eight-bit command framing
// - Clock level at select fall picks mode
// - Plain read: opcode, three address bytes, data
// - Fast read adds one dummy byte
// - Dual read: dummy byte, data on two lines
// - Dual I/O read: two-line address, dummy
// - Sector erase with three address bytes
// - Chip erase on two opcodes, no address
// - Program: address then data bytes
// - Power-down entered and left by opcode
// - Status read returns status byte
// - Status write takes one data byte
// - Five top address bits are ignored
// - Reads auto-increment and wrap at top
// - Output released while deselected
`timescale 1ns/100ps
`default_nettype none
`include "sfc_params.svh"
module sfc_port (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Serial link pins
  input wire logic SERIAL_CLK,
  input wire logic CHIP_SEL_N,
  input wire logic HOLD_N,
  input wire logic WRITE_PROT_N,
  input wire logic DATA_LINE_ZERO_IN,
  output logic DATA_LINE_ZERO_OUT,
  output logic DATA_LINE_ZERO_OE,
  input wire logic DATA_LINE_ONE_IN,
  output logic DATA_LINE_ONE_OUT,
  output logic DATA_LINE_ONE_OE,
  // Array read
  output logic [18:0] RD_ADDR,
  input wire logic [7:0] RD_DATA,
  // Status inputs
  input wire logic [7:0] STATUS_BITS,
  input wire logic BUSY,
  input wire logic STATUS_WRITE_LOCK,
  // Command strobe
  output logic CMD_STB,
  output sfc_pkg::sfc_kind_e CMD_KIND,
  output logic [7:0] STATUS_DATA,
  // Program data
  output logic PROG_VALID,
  input wire logic PROG_READY,
  output logic [7:0] PROGRAM_DATA_BYTE,
  output logic PROG_OVERRUN,
  // State
  output logic WRITE_ENABLED,
  output logic POWER_DOWN,
  output logic SPI_MODE3,
  output logic SELECTED
);
  import sfc_pkg::*;

  // =====================================
  // Pin synchronisers
  logic sck_s, cs_s, hold_s, wp_s, d0_s, d1_s;
  logic sck_d, cs_d, sel_reg;
  // Reset levels are the idle pins: select high, hold and protect high
  sfc_sync #(.W(6), .RST_VAL(6'h1C)) u_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .async_in({SERIAL_CLK, CHIP_SEL_N, HOLD_N, WRITE_PROT_N, DATA_LINE_ZERO_IN, DATA_LINE_ONE_IN}),
    .sync_out({sck_s, cs_s, hold_s, wp_s, d0_s, d1_s})
  );

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      sck_d <= 1'h0;
      cs_d <= 1'h1;
      sel_reg <= 1'h0;
    end
    else
    begin
      sck_d <= sck_s;
      cs_d <= cs_s;
      sel_reg <= ~cs_s;
    end
  end

  logic active, rise, fall, cs_fall, cs_rise;
  assign active = ~cs_s & ~cs_d & hold_s;
  assign rise = active & sck_s & ~sck_d;
  assign fall = active & ~sck_s & sck_d;
  assign cs_fall = ~cs_s & cs_d;
  assign cs_rise = cs_s & ~cs_d;

  // =====================================
  // Framing state
  sfc_state_e state_reg;
  sfc_src_e src_reg;
  logic [4:0] cnt_reg;
  logic [23:0] sh_in_reg;
  logic [7:0] op_reg;
  logic dual_in_reg, dual_out_reg, mode_reg;
  logic [23:0] sh_now;
  logic last, op_done, addr_end, byte_done;
  logic [7:0] opc;

  assign sh_now = dual_in_reg ? {sh_in_reg[21:0], d1_s, d0_s} : {sh_in_reg[22:0], d0_s};
  assign opc = sh_now[7:0];
  assign last = cnt_reg == 5'h01;
  assign op_done = rise && state_reg == ST_CMD && last;
  assign addr_end = rise && state_reg == ST_ADDR && last;
  assign byte_done = rise && state_reg == ST_IN && last;

  logic wel_reg, pdn_reg;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      mode_reg <= 1'h0;
    else if (cs_fall)
      mode_reg <= sck_s;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || cs_s)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 5'h00;
      src_reg <= SRC_ARRAY;
      dual_out_reg <= 1'h0;
      dual_in_reg <= 1'h0;
    end
    else if (cs_fall)
    begin
      state_reg <= ST_CMD;
      cnt_reg <= `SFC_CLK_BYTE;
      dual_in_reg <= 1'h0;
    end
    else if (rise)
    begin
      sh_in_reg <= sh_now;
      cnt_reg <= cnt_reg - 5'h01;
      unique case (state_reg)
        ST_CMD:
          if (last)
          begin
            op_reg <= opc;
            src_reg <= SRC_ARRAY;
            dual_out_reg <= opc == `SFC_OP_DUAL || opc == `SFC_OP_DIO;
            state_reg <= ST_SKIP;
            if (!pdn_reg || opc == `SFC_OP_LEGACY)
              unique case (opc)
                `SFC_OP_READ, `SFC_OP_FAST, `SFC_OP_DUAL, `SFC_OP_PROG,
                `SFC_OP_ERS_S1, `SFC_OP_ERS_S2, `SFC_OP_ERS_SEC:
                begin
                  state_reg <= ST_ADDR;
                  cnt_reg <= `SFC_CLK_ADDR_X1;
                end
                `SFC_OP_DIO:
                begin
                  state_reg <= ST_ADDR;
                  cnt_reg <= `SFC_CLK_ADDR_X2;
                  dual_in_reg <= 1'h1;
                end
                `SFC_OP_RDST:
                begin
                  state_reg <= ST_OUT;
                  src_reg <= SRC_STATUS;
                end
                `SFC_OP_ID:
                begin
                  state_reg <= ST_OUT;
                  src_reg <= SRC_ID;
                end
                `SFC_OP_LEGACY:
                begin
                  state_reg <= ST_DUMMY;
                  cnt_reg <= `SFC_CLK_DUMMY_LEGACY;
                  src_reg <= SRC_LEGACY;
                end
                `SFC_OP_WRST:
                begin
                  state_reg <= ST_IN;
                  cnt_reg <= `SFC_CLK_BYTE;
                end
                default:
                  state_reg <= ST_SKIP;
              endcase
          end
        ST_ADDR:
          if (last)
          begin
            dual_in_reg <= 1'h0;
            unique case (op_reg)
              `SFC_OP_READ:
                state_reg <= ST_OUT;
              `SFC_OP_FAST, `SFC_OP_DUAL:
              begin
                state_reg <= ST_DUMMY;
                cnt_reg <= `SFC_CLK_DUMMY_FAST;
              end
              `SFC_OP_DIO:
              begin
                state_reg <= ST_DUMMY;
                cnt_reg <= `SFC_CLK_DUMMY_DIO;
              end
              `SFC_OP_PROG:
              begin
                state_reg <= ST_IN;
                cnt_reg <= `SFC_CLK_BYTE;
              end
              default:
                state_reg <= ST_SKIP;
            endcase
          end
        ST_DUMMY:
          if (last)
            state_reg <= ST_OUT;
        ST_IN:
          if (last)
            cnt_reg <= `SFC_CLK_BYTE;
        ST_OUT, ST_SKIP, ST_IDLE:
          cnt_reg <= cnt_reg;
      endcase
    end
  end

  // =====================================
  // Address counter
  logic [18:0] addr_reg;
  logic [2:0] ocnt_reg;
  logic load, load_array;
  assign load = fall && state_reg == ST_OUT && ocnt_reg == 3'h0;
  assign load_array = load && src_reg == SRC_ARRAY;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      addr_reg <= 19'h00000;
    else if (addr_end)
      addr_reg <= sh_now[18:0];
    else if (load_array)
      addr_reg <= addr_reg + 19'h00001;
  end

  // =====================================
  // Output shifter
  logic [7:0] sh_out_reg;
  logic [1:0] id_idx_reg;
  logic drv0_reg, drv1_reg, q0_reg, q1_reg;
  logic [7:0] src_byte;

  always_comb
  begin
    unique case (src_reg)
      SRC_ARRAY: src_byte = RD_DATA;
      SRC_STATUS: src_byte = {STATUS_BITS[7:2], wel_reg, BUSY};
      SRC_ID: src_byte = 8'(`SFC_ID_STD >> (5'h10 - {id_idx_reg, 3'h0}));
      SRC_LEGACY: src_byte = `SFC_ID_LEGACY;
    endcase
  end

  // Reads repeat while clocked; the id cycles through its three bytes
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N || cs_s || cs_fall)
    begin
      ocnt_reg <= 3'h0;
      id_idx_reg <= 2'h0;
      drv0_reg <= 1'h0;
      drv1_reg <= 1'h0;
      q0_reg <= 1'h0;
      q1_reg <= 1'h0;
      sh_out_reg <= 8'h00;
    end
    else if (fall && state_reg == ST_OUT)
    begin
      drv1_reg <= 1'h1;
      drv0_reg <= dual_out_reg;
      if (ocnt_reg == 3'h0)
      begin
        id_idx_reg <= (id_idx_reg == 2'h2) ? 2'h0 : id_idx_reg + 2'h1;
        if (dual_out_reg)
        begin
          q0_reg <= src_byte[7];
          q1_reg <= src_byte[6];
          sh_out_reg <= {src_byte[5:0], 2'h0};
          ocnt_reg <= 3'h3;
        end
        else
        begin
          q1_reg <= src_byte[7];
          sh_out_reg <= {src_byte[6:0], 1'h0};
          ocnt_reg <= 3'h7;
        end
      end
      else
      begin
        ocnt_reg <= ocnt_reg - 3'h1;
        if (dual_out_reg)
        begin
          q0_reg <= sh_out_reg[7];
          q1_reg <= sh_out_reg[6];
          sh_out_reg <= {sh_out_reg[5:0], 2'h0};
        end
        else
        begin
          q1_reg <= sh_out_reg[7];
          sh_out_reg <= {sh_out_reg[6:0], 1'h0};
        end
      end
    end
  end

  // Pins float during hold so the host may share the lines
  logic oe0_reg, oe1_reg;
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      oe0_reg <= 1'h0;
      oe1_reg <= 1'h0;
    end
    else
    begin
      oe0_reg <= drv0_reg & hold_s & ~cs_s;
      oe1_reg <= drv1_reg & hold_s & ~cs_s;
    end
  end

  // =====================================
  // Write control
  sfc_kind_e pend_reg, kind_reg;
  logic stb_reg, prog_reg, ovr_reg;
  logic [7:0] sd_reg;
  logic buf_ready;
  logic sr_ok;
  assign sr_ok = wp_s | ~STATUS_WRITE_LOCK;

  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      wel_reg <= `SFC_RST_WEL;
      pdn_reg <= `SFC_RST_PDOWN;
      pend_reg <= K_NONE;
      kind_reg <= K_NONE;
      stb_reg <= 1'h0;
      prog_reg <= 1'h0;
      sd_reg <= 8'h00;
    end
    else
    begin
      stb_reg <= 1'h0;
      if (cs_s)
        prog_reg <= 1'h0;
      if (op_done && !pdn_reg)
        unique case (opc)
          `SFC_OP_WEN: wel_reg <= 1'h1;
          `SFC_OP_WDIS: wel_reg <= 1'h0;
          `SFC_OP_PDOWN: pdn_reg <= 1'h1;
          `SFC_OP_ERS_C1, `SFC_OP_ERS_C2: pend_reg <= K_ERASE_CHIP;
          default: pend_reg <= K_NONE;
        endcase
      if (op_done && opc == `SFC_OP_LEGACY)
        pdn_reg <= 1'h0;
      if (addr_end)
        unique case (op_reg)
          `SFC_OP_ERS_S1, `SFC_OP_ERS_S2: pend_reg <= K_ERASE_SMALL;
          `SFC_OP_ERS_SEC: pend_reg <= K_ERASE_SECTOR;
          `SFC_OP_PROG:
            if (wel_reg)
            begin
              prog_reg <= 1'h1;
              stb_reg <= 1'h1;
              kind_reg <= K_PROGRAM;
              wel_reg <= 1'h0;
            end
          default: pend_reg <= K_NONE;
        endcase
      // Clocks past the end of an erase frame void it
      if (rise && state_reg == ST_SKIP)
        pend_reg <= K_NONE;
      if (byte_done && op_reg == `SFC_OP_WRST && wel_reg && sr_ok)
      begin
        stb_reg <= 1'h1;
        kind_reg <= K_STATUS_WR;
        sd_reg <= sh_now[7:0];
        wel_reg <= 1'h0;
      end
      if (cs_rise)
      begin
        pend_reg <= K_NONE;
        if (pend_reg != K_NONE && wel_reg)
        begin
          stb_reg <= 1'h1;
          kind_reg <= pend_reg;
          wel_reg <= 1'h0;
        end
      end
    end
  end

  // =====================================
  // Program data buffer
  logic push;
  assign push = byte_done && prog_reg;
  sfc_buf #(.W(8), .D(2)) u_buf (
    .clk(CLOCK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_ready(buf_ready),
    .in_data(sh_now[7:0]),
    .out_valid(PROG_VALID),
    .out_ready(PROG_READY),
    .out_data(PROGRAM_DATA_BYTE)
  );

  // The link cannot stall, so a full buffer can only be reported
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
      ovr_reg <= 1'h0;
    else
      ovr_reg <= push & ~buf_ready;
  end

  assign DATA_LINE_ZERO_OUT = q0_reg;
  assign DATA_LINE_ZERO_OE = oe0_reg;
  assign DATA_LINE_ONE_OUT = q1_reg;
  assign DATA_LINE_ONE_OE = oe1_reg;
  assign RD_ADDR = addr_reg;
  assign CMD_STB = stb_reg;
  assign CMD_KIND = kind_reg;
  assign STATUS_DATA = sd_reg;
  assign PROG_OVERRUN = ovr_reg;
  assign WRITE_ENABLED = wel_reg;
  assign POWER_DOWN = pdn_reg;
  assign SPI_MODE3 = mode_reg;
  assign SELECTED = sel_reg;

  // =====================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_cmd_capture: assert property (op_done |=> op_reg == $past(opc))
    else $error("opcode not taken on rise");
  a_out_on_fall: assert property ($changed(q1_reg) && !cs_s |-> $past(fall))
    else $error("output changed off falling edge");
  a_dual_drive: assert property (drv1_reg && dual_out_reg |-> drv0_reg)
    else $error("dual mode drives one line");
  a_deselect_hiz: assert property (cs_s |=> !DATA_LINE_ONE_OE && !DATA_LINE_ZERO_OE)
    else $error("driving while deselected");
  a_status_lock: assert property (stb_reg && kind_reg == K_STATUS_WR |-> $past(sr_ok))
    else $error("status written while locked");
  a_hold_freeze: assert property (!hold_s && !cs_s && !cs_d |=> $stable(cnt_reg))
    else $error("link advanced during hold");
  a_frame_start: assert property (cs_fall |=> state_reg == ST_CMD && cnt_reg == 5'h08)
    else $error("command framing not started");
  a_mode_pick: assert property (cs_fall |=> mode_reg == $past(sck_s))
    else $error("mode not sampled");
  a_read_start: assert property (addr_end && op_reg == `SFC_OP_READ |=> state_reg == ST_OUT)
    else $error("read data not next");
  a_addr_wrap: assert property (load_array && addr_reg == `SFC_ADDR_MAX |=> addr_reg == 19'h00000)
    else $error("address did not wrap");
  a_addr_low: assert property (addr_end |=> addr_reg == $past(sh_now[18:0]))
    else $error("address bits wrong");
  a_pdown_gate: assert property (pdn_reg && op_done && opc != `SFC_OP_LEGACY |=> state_reg == ST_SKIP)
    else $error("command accepted in power-down");

  c_read: cover property (load_array ##[1:300] load_array);
  c_dual_io: cover property (load && op_reg == `SFC_OP_DIO);
  c_prog_push: cover property (push && buf_ready);
endmodule // sfc_port
`default_nettype wire

// ===== bench/sfc_host.sv
// Behavioural SPI host driving the serial link of the port.
// Assumes CLOCK at 8x the serial clock; used through its tasks.
`timescale 1ns/100ps
`default_nettype none
module sfc_host (
  // Clock
  input wire logic clk,
  // Link
  output logic sck,
  output logic cs_n,
  output logic d0,
  output logic d1,
  output logic drv0,
  output logic drv1,
  input wire logic q0,
  input wire logic q1
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    d0 = 1'b0;
    d1 = 1'b0;
    drv0 = 1'b0;
    drv1 = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start(input logic mode3);
    sck <= mode3;
    wait_clk(4);
    cs_n <= 1'b0;
    wait_clk(4);
  endtask
  // Released lines toggle every bit so a stale value never passes
  task automatic shift(input logic [7:0] tx, input logic dual, input logic rd, output logic [7:0] rx);
    int n;
    n = dual ? 4 : 8;
    for (int i = 0; i < n; i++)
    begin
      sck <= 1'b0;
      drv0 <= !rd;
      drv1 <= dual && !rd;
      d0 <= rd ? ~d0 : (dual ? tx[6-2*i] : tx[7-i]);
      d1 <= (dual && !rd) ? tx[7-2*i] : ~d1;
      wait_clk(4);
      sck <= 1'b1;
      wait_clk(4);
      if (dual)
      begin
        rx[7-2*i] = q0;
        rx[6-2*i] = q1;
      end
      else
        rx[7-i] = q1;
    end
  endtask
  // Select held over the whole command, released after the last unit
  task automatic stop(input logic mode3);
    sck <= mode3;
    drv0 <= 1'b0;
    drv1 <= 1'b0;
    wait_clk(4);
    cs_n <= 1'b1;
    wait_clk(8);
  endtask
endmodule // sfc_host
`default_nettype wire

// ===== bench/serial_flash_command_port_bench.sv
// Self-checking bench of the serial flash command port.
// Assumes hw/ on the include path and sfc_host as link controller.
`timescale 1ns/100ps
`default_nettype none
`include "sfc_params.svh"
module serial_flash_command_port_bench;
  import sfc_pkg::*;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic HOLD_N = 1'b1;
  logic WRITE_PROT_N = 1'b1;
  logic [7:0] RD_DATA;
  logic [7:0] STATUS_BITS;
  logic BUSY;
  logic STATUS_WRITE_LOCK = 1'b0;
  logic PROG_READY = 1'b0;
  wire logic sck, cs_n, d0, d1, drv0, drv1, o0, e0, o1, e1, stb, pv, ovr, wen, pdn, m3, sel;
  logic [18:0] rd_addr;
  sfc_kind_e kind;
  logic [7:0] sdata, pbyte, rx;
  logic [23:0] a;
  logic [23:0] id_std = `SFC_ID_STD;
  logic [7:0] rop[4] = '{`SFC_OP_READ, `SFC_OP_FAST, `SFC_OP_DUAL, `SFC_OP_DIO};
  logic [7:0] eop[5] = '{`SFC_OP_ERS_S1, `SFC_OP_ERS_S2, `SFC_OP_ERS_SEC, `SFC_OP_ERS_C1, `SFC_OP_ERS_C2};
  sfc_kind_e ekd[5] = '{K_ERASE_SMALL, K_ERASE_SMALL, K_ERASE_SECTOR, K_ERASE_CHIP, K_ERASE_CHIP};
  int ena[5] = '{3, 3, 3, 0, 0};
  int num_errors = 0;
  int n_checks = 0;
  int stb_cnt = 0;
  int ovr_cnt = 0;
  int n;
  logic [7:0] taken[$];
  always #20 CLOCK = ~CLOCK;
  sfc_port sfc_port_i (.CLOCK(CLOCK), .RST_N(RST_N), .SERIAL_CLK(sck), .CHIP_SEL_N(cs_n), .HOLD_N(HOLD_N),
    .WRITE_PROT_N(WRITE_PROT_N), .DATA_LINE_ZERO_IN(e0 ? o0 : d0), .DATA_LINE_ZERO_OUT(o0),
    .DATA_LINE_ZERO_OE(e0), .DATA_LINE_ONE_IN(e1 ? o1 : d1), .DATA_LINE_ONE_OUT(o1), .DATA_LINE_ONE_OE(e1),
    .RD_ADDR(rd_addr), .RD_DATA(RD_DATA), .STATUS_BITS(STATUS_BITS), .BUSY(BUSY),
    .STATUS_WRITE_LOCK(STATUS_WRITE_LOCK), .CMD_STB(stb), .CMD_KIND(kind), .STATUS_DATA(sdata),
    .PROG_VALID(pv), .PROG_READY(PROG_READY), .PROGRAM_DATA_BYTE(pbyte), .PROG_OVERRUN(ovr),
    .WRITE_ENABLED(wen), .POWER_DOWN(pdn), .SPI_MODE3(m3), .SELECTED(sel));
  sfc_host sfc_host_i (.clk(CLOCK), .sck(sck), .cs_n(cs_n), .d0(d0), .d1(d1), .drv0(drv0), .drv1(drv1),
    .q0(e0 ? o0 : d0), .q1(e1 ? o1 : d1));
  function automatic logic [7:0] mem(input logic [18:0] x);
    return x[7:0] ^ {x[18:12], 1'b0};
  endfunction
  task automatic fail(input string m);
    $display("[ERR] %0t %s", $time, m);
    num_errors++;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) fail(m);
  endtask
  // Array model and event counters
  always @(posedge CLOCK)
  begin
    RD_DATA <= mem(rd_addr);
    if (stb === 1'b1) stb_cnt <= stb_cnt + 1;
    if (ovr === 1'b1) ovr_cnt <= ovr_cnt + 1;
    if (pv === 1'b1 && PROG_READY) taken.push_back(pbyte);
    if ((e0 & drv0) === 1'b1 || (e1 & drv1) === 1'b1) fail("line contention");
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK);
  endtask
  task automatic head(input logic [7:0] op, input logic [23:0] x, input int na, input logic md);
    sfc_host_i.start(md);
    sfc_host_i.shift(op, 1'b0, 1'b0, rx);
    for (int i = 0; i < na; i++) sfc_host_i.shift(x[23-8*i -: 8], op == `SFC_OP_DIO, 1'b0, rx);
  endtask
  task automatic get(input logic dual, input logic [7:0] e, input string m);
    sfc_host_i.shift(8'h00, dual, 1'b1, rx);
    chk(rx, e, m);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] x, input int na);
    head(op, x, na, 1'b0);
    sfc_host_i.stop(1'b0);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog: the run is far shorter than this
  initial
  begin
    cyc(60000);
    fail("timeout");
    print_verdict();
  end
  initial
  begin
    cyc(4);
    STATUS_BITS <= 8'hA4;
    BUSY <= 1'b1;
    RST_N <= 1'b1;
    cyc(1);
    chk({e0, e1, stb, wen, pdn, sel, pv}, 7'h00, "reset values");
    cyc(4);
    foreach (rop[i])
    begin
      a = 24'hF80010 + 24'h000111 * i;
      head(rop[i], a, 3, i[0]);
      if (i > 0) sfc_host_i.shift(8'h00, i == 3, i > 1, rx);
      get(i > 1, mem(a[18:0]), "first byte");
      get(i > 1, mem(a[18:0] + 19'h1), "next byte");
      chk({e0, e1, sel, m3}, {i > 1, 1'b1, 1'b1, i[0]}, "enables, mode");
      sfc_host_i.stop(i[0]);
      cyc(6);
      chk({e0, e1, sel}, 3'h0, "released");
    end
    head(`SFC_OP_READ, 24'h07FFFF, 3, 1'b1);
    get(1'b0, mem(19'h7FFFF), "top byte");
    get(1'b0, mem(19'h00000), "wrapped byte");
    sfc_host_i.stop(1'b1);
    $display("test done: reads");
    head(`SFC_OP_RDST, 24'h0, 0, 1'b0);
    get(1'b0, {STATUS_BITS[7:2], 1'b0, BUSY}, "status");
    sfc_host_i.stop(1'b0);
    cmd(`SFC_OP_WEN, 24'h0, 0);
    chk(wen, 1'b1, "latch set");
    STATUS_BITS <= 8'h58;
    BUSY <= 1'b0;
    head(`SFC_OP_RDST, 24'h0, 0, 1'b0);
    get(1'b0, {STATUS_BITS[7:2], 1'b1, BUSY}, "status latch");
    HOLD_N <= 1'b0;
    cyc(6);
    chk(e1, 1'b0, "hold floats");
    HOLD_N <= 1'b1;
    sfc_host_i.stop(1'b0);
    cmd(`SFC_OP_WDIS, 24'h0, 0);
    chk(wen, 1'b0, "latch cleared");
    head(`SFC_OP_ID, 24'h0, 0, 1'b0);
    for (int i = 0; i < 3; i++) get(1'b0, id_std[23-8*i -: 8], "id");
    sfc_host_i.stop(1'b0);
    head(`SFC_OP_LEGACY, 24'h0, 3, 1'b0);
    get(1'b0, `SFC_ID_LEGACY, "legacy id");
    sfc_host_i.stop(1'b0);
    $display("test done: status and id");
    foreach (eop[i])
    begin
      cmd(`SFC_OP_WEN, 24'h0, 0);
      n = stb_cnt;
      cmd(eop[i], 24'hE12345, ena[i]);
      chk(stb_cnt - n, 1, "erase strobe");
      chk({kind, wen}, {ekd[i], 1'b0}, "erase kind");
      if (ena[i] > 0) chk(rd_addr, 19'h12345, "erase address");
    end
    n = stb_cnt;
    cmd(`SFC_OP_ERS_SEC, 24'h0, 3);
    cmd(`SFC_OP_WEN, 24'h0, 0);
    cmd(`SFC_OP_WRST, 24'hA50000, 1);
    chk({8'(stb_cnt - n), kind, sdata}, {8'd1, K_STATUS_WR, 8'hA5}, "status write");
    STATUS_WRITE_LOCK <= 1'b1;
    WRITE_PROT_N <= 1'b0;
    cmd(`SFC_OP_WEN, 24'h0, 0);
    n = stb_cnt;
    cmd(`SFC_OP_WRST, 24'h5A0000, 1);
    chk(stb_cnt - n, 0, "locked write");
    WRITE_PROT_N <= 1'b1;
    $display("test done: erase and status write");
    cmd(`SFC_OP_WEN, 24'h0, 0);
    n = stb_cnt;
    head(`SFC_OP_PROG, 24'h000200, 3, 1'b0);
    for (int i = 0; i < 3; i++) sfc_host_i.shift(8'h30 + i[7:0], 1'b0, 1'b0, rx);
    sfc_host_i.stop(1'b0);
    chk({8'(stb_cnt - n), kind, pv}, {8'd1, K_PROGRAM, 1'b1}, "program held");
    chk(ovr_cnt, 1, "overrun");
    PROG_READY <= 1'b1;
    cyc(4);
    chk({8'(taken.size()), taken[0], taken[1], pv}, {8'd2, 8'h30, 8'h31, 1'b0}, "drained");
    $display("test done: program");
    cmd(`SFC_OP_WEN, 24'h0, 0);
    cmd(`SFC_OP_PDOWN, 24'h0, 0);
    chk(pdn, 1'b1, "power down");
    cmd(`SFC_OP_WDIS, 24'h0, 0);
    chk(wen, 1'b1, "ignored");
    cmd(`SFC_OP_LEGACY, 24'h0, 0);
    chk(pdn, 1'b0, "woken");
    $display("test done: power");
    print_verdict();
  end
endmodule // serial_flash_command_port_bench
`default_nettype wire
